/* File: pll_lock_map.svh */
// Register map, field positions, reset values and timing counts
`ifndef PLL_LOCK_MAP_SVH
`define PLL_LOCK_MAP_SVH

`define LD_CLK_PERIOD_NS 4

// Register indices; byte address is four times the index
`define LD_CFG_IDX 6'h19
`define LD_STATUS_IDX 6'h20
`define LD_ISTAT_IDX 6'h21
`define LD_IMASK_IDX 6'h22

`define LD_CFG_RESET 8'h00
`define LD_ISTAT_RESET 8'h00
`define LD_IMASK_RESET 8'h00

`define LD_CFG_DIS_BIT 0
`define LD_CFG_WIN_BIT 1
`define LD_CFG_CNT_LSB 2
`define LD_CFG_CNT_MSB 3

`define LD_IRQ_ACQ_BIT 0
`define LD_IRQ_LOST_BIT 1

`define LD_CNT_SEL0 8'h05
`define LD_CNT_SEL1 8'h10
`define LD_CNT_SEL2 8'h40
`define LD_CNT_SEL3 8'hFF

// Lock window and loss-of-lock threshold times, all cycle counts round down
`define LD_WIN_HI_NS 16
`define LD_WIN_LO_NS 8
`define LD_LOL_HI_NS 32
`define LD_LOL_LO_NS 16
`define LD_WIN_HI_CYC (`LD_WIN_HI_NS / `LD_CLK_PERIOD_NS)
`define LD_WIN_LO_CYC (`LD_WIN_LO_NS / `LD_CLK_PERIOD_NS)
`define LD_LOL_HI_CYC (`LD_LOL_HI_NS / `LD_CLK_PERIOD_NS)
`define LD_LOL_LO_CYC (`LD_LOL_LO_NS / `LD_CLK_PERIOD_NS)

`define LD_SKEW_MAX 8'hFF

`define LD_RESP_OKAY 2'h0
`define LD_RESP_SLVERR 2'h2

`endif

/* File: pll_lock_pkg.sv */
// Types shared by the lock detector modules
package pll_lock_pkg;

    typedef enum logic [1:0] {LK_OFF, LK_ACQ, LK_LOCKED} lock_state_t;

    typedef enum logic {SK_IDLE, SK_WAIT} skew_state_t;

endpackage

/* File: edge_sync3.sv */
// Three-stage pin synchroniser with rising edge detection
`timescale 1ns/1ns

module edge_sync3
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_rise
);

    logic s1;
    logic s2;
    logic s3;
    logic stable;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stable <= 1'b0;
            o_rise <= 1'b0;
        end
        else
        begin
            o_rise <= (s2 == s3) && s2 && !stable;
            if (s2 == s3)
                stable <= s2;
        end
    end

endmodule

/* File: edge_skew_meter.sv */
// Measures reference to feedback rising edge skew in clock cycles
`timescale 1ns/1ns

module edge_skew_meter
    import pll_lock_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_ref_rise,
    input wire logic i_fb_rise,
    output logic o_done,
    output logic [7:0] o_skew
);
`include "pll_lock_map.svh"

    skew_state_t state;
    logic lead_ref;
    logic [7:0] cnt;
    logic lead_again;
    logic other;

    always_comb
    begin
        lead_again = lead_ref ? i_ref_rise : i_fb_rise;
        other = lead_ref ? i_fb_rise : i_ref_rise;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= SK_IDLE;
            lead_ref <= 1'b0;
            cnt <= 8'h00;
            o_done <= 1'b0;
            o_skew <= 8'h00;
        end
        else
        begin
            o_done <= 1'b0;
            if (!i_enable)
            begin
                state <= SK_IDLE;
                cnt <= 8'h00;
            end
            else
            begin
                case (state)
                    SK_IDLE:
                    begin
                        if (i_ref_rise && i_fb_rise)
                        begin
                            o_done <= 1'b1;
                            o_skew <= 8'h00;
                        end
                        else if (i_ref_rise || i_fb_rise)
                        begin
                            state <= SK_WAIT;
                            lead_ref <= i_ref_rise;
                            cnt <= 8'h01;
                        end
                    end
                    SK_WAIT:
                    begin
                        if (other)
                        begin
                            o_done <= 1'b1;
                            o_skew <= cnt;
                            state <= SK_IDLE;
                        end
                        else if (lead_again || cnt == `LD_SKEW_MAX)
                        begin
                            // Missing partner edge: report worst skew
                            o_done <= 1'b1;
                            o_skew <= `LD_SKEW_MAX;
                            cnt <= 8'h01;
                            if (!lead_again)
                                state <= SK_IDLE;
                        end
                        else
                            cnt <= cnt + 8'h01;
                    end
                    default:
                        state <= SK_IDLE;
                endcase
            end
        end
    end

endmodule

/* File: pll_lock_detect.sv */
// Digital lock detector with AXI4-Lite registers and interrupt
`timescale 1ns/1ns

module pll_lock_detect
    import pll_lock_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pfd_ref,
    input wire logic i_pfd_fb,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic o_digital_lock_flag,
    output logic o_irq
);
`include "pll_lock_map.svh"

    logic [1:0] pin_rise;
    logic meas_done;
    logic [7:0] meas_skew;
    logic [7:0] lock_cfg;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_stat;
    logic [7:0] irq_evt;
    lock_state_t state;
    logic [7:0] run_cnt;
    logic [7:0] last_skew;
    logic [7:0] win_cyc;
    logic [7:0] lol_cyc;
    logic [7:0] target;
    logic in_window;
    logic lost;
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic detect_on;

    function automatic logic [7:0] count_target(input logic [1:0] sel);
        case (sel)
            2'h0: count_target = `LD_CNT_SEL0;
            2'h1: count_target = `LD_CNT_SEL1;
            2'h2: count_target = `LD_CNT_SEL2;
            default: count_target = `LD_CNT_SEL3;
        endcase
    endfunction

    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx == `LD_CFG_IDX) || (idx == `LD_STATUS_IDX) ||
            (idx == `LD_ISTAT_IDX) || (idx == `LD_IMASK_IDX);
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_sync
            edge_sync3 u_sync
            (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_pin(g == 0 ? i_pfd_ref : i_pfd_fb),
                .o_rise(pin_rise[g])
            );
        end
    endgenerate

    assign detect_on = !lock_cfg[`LD_CFG_DIS_BIT];

    edge_skew_meter u_meter
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_enable(detect_on),
        .i_ref_rise(pin_rise[0]),
        .i_fb_rise(pin_rise[1]),
        .o_done(meas_done),
        .o_skew(meas_skew)
    );

    // Only bits [3:0] are decoded; the upper nibble is stored for readback
    always_comb
    begin
        if (lock_cfg[`LD_CFG_WIN_BIT])
        begin
            win_cyc = 8'(`LD_WIN_LO_CYC);
            lol_cyc = 8'(`LD_LOL_LO_CYC);
        end
        else
        begin
            win_cyc = 8'(`LD_WIN_HI_CYC);
            lol_cyc = 8'(`LD_LOL_HI_CYC);
        end
        target = count_target(
            lock_cfg[`LD_CFG_CNT_MSB:`LD_CFG_CNT_LSB]);
        in_window = meas_skew < win_cyc;
        // Threshold above window gives hysteresis against flag chatter
        lost = meas_skew > lol_cyc;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= LK_OFF;
            run_cnt <= 8'h00;
            o_digital_lock_flag <= 1'b0;
            irq_evt <= 8'h00;
        end
        else
        begin
            irq_evt <= 8'h00;
            if (!detect_on)
            begin
                state <= LK_OFF;
                run_cnt <= 8'h00;
                o_digital_lock_flag <= 1'b0;
                if (state == LK_LOCKED)
                    irq_evt[`LD_IRQ_LOST_BIT] <= 1'b1;
            end
            else
            begin
                case (state)
                    LK_OFF:
                    begin
                        state <= LK_ACQ;
                        run_cnt <= 8'h00;
                    end
                    LK_ACQ:
                    begin
                        if (meas_done)
                        begin
                            if (!in_window)
                                run_cnt <= 8'h00;
                            else if (run_cnt + 8'h01 >= target)
                            begin
                                state <= LK_LOCKED;
                                run_cnt <= 8'h00;
                                o_digital_lock_flag <= 1'b1;
                                irq_evt[`LD_IRQ_ACQ_BIT] <= 1'b1;
                            end
                            else
                                run_cnt <= run_cnt + 8'h01;
                        end
                    end
                    LK_LOCKED:
                    begin
                        if (meas_done && lost)
                        begin
                            state <= LK_ACQ;
                            o_digital_lock_flag <= 1'b0;
                            irq_evt[`LD_IRQ_LOST_BIT] <= 1'b1;
                        end
                    end
                    default:
                    begin
                        state <= LK_OFF;
                        o_digital_lock_flag <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
            last_skew <= 8'h00;
        else if (meas_done)
            last_skew <= meas_skew;
    end

    // Write address channel
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
        end
        else if (i_s_axi_awvalid && o_s_axi_awready)
        begin
            o_s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_idx <= i_s_axi_awaddr[7:2];
        end
        else if (do_write)
            aw_held <= 1'b0;
        else if (!aw_held && !o_s_axi_bvalid)
            o_s_axi_awready <= 1'b1;
    end

    // Write data channel
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (i_s_axi_wvalid && o_s_axi_wready)
        begin
            o_s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= i_s_axi_wdata;
            w_strb <= i_s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
        else if (!w_held && !o_s_axi_bvalid)
            o_s_axi_wready <= 1'b1;
    end

    assign do_write = aw_held && w_held && !o_s_axi_bvalid;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `LD_RESP_OKAY;
        end
        else if (do_write)
        begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= idx_mapped(aw_idx) ? `LD_RESP_OKAY
                                                : `LD_RESP_SLVERR;
        end
        else if (o_s_axi_bvalid && i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lock_cfg <= `LD_CFG_RESET;
            irq_mask <= `LD_IMASK_RESET;
        end
        else if (do_write && w_strb[0])
        begin
            if (aw_idx == `LD_CFG_IDX)
                lock_cfg <= w_data[7:0];
            if (aw_idx == `LD_IMASK_IDX)
                irq_mask <= w_data[7:0];
        end
    end

    // Write-one-to-clear; a new event in the clearing cycle still sets
    always_comb
    begin
        next_irq_stat = irq_stat;
        if (do_write && w_strb[0] && aw_idx == `LD_ISTAT_IDX)
            next_irq_stat = irq_stat & ~w_data[7:0];
        next_irq_stat = next_irq_stat | irq_evt;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_stat <= `LD_ISTAT_RESET;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            o_irq <= |(next_irq_stat & irq_mask);
        end
    end

    function automatic logic [31:0] reg_read(input logic [5:0] idx);
        case (idx)
            `LD_CFG_IDX: reg_read = {24'h000000, lock_cfg};
            `LD_STATUS_IDX: reg_read = {8'h00, run_cnt, last_skew, 5'h00,
                                        state, o_digital_lock_flag};
            `LD_ISTAT_IDX: reg_read = {24'h000000, irq_stat};
            `LD_IMASK_IDX: reg_read = {24'h000000, irq_mask};
            default: reg_read = 32'h0000_0000;
        endcase
    endfunction

    // Read channel
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= `LD_RESP_OKAY;
        end
        else if (i_s_axi_arvalid && o_s_axi_arready)
        begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= reg_read(i_s_axi_araddr[7:2]);
            o_s_axi_rresp <= idx_mapped(i_s_axi_araddr[7:2]) ? `LD_RESP_OKAY
                                                             : `LD_RESP_SLVERR;
        end
        else if (o_s_axi_rvalid && i_s_axi_rready)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end
        else if (!o_s_axi_rvalid)
            o_s_axi_arready <= 1'b1;
    end

endmodule

/* File: pll_lock_detect_asserts.sv */
// Bus handshake and lock flag checks for the lock detector
`timescale 1ns/1ns

module pll_lock_detect_asserts
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_pfd_ref,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic o_digital_lock_flag,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic ref_q;
    logic [7:0] ref_rises;

    // Saturates so a long unlocked stretch cannot wrap to a small count
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ref_q <= 1'b0;
            ref_rises <= 8'h00;
        end
        else
        begin
            ref_q <= i_pfd_ref;
            if (o_digital_lock_flag)
                ref_rises <= 8'h00;
            else if (i_pfd_ref && !ref_q && ref_rises != 8'hFF)
                ref_rises <= ref_rises + 8'h01;
        end
    end

    // One edge may already sit in the synchroniser when the flag falls
    property p_lock_needs_edges;
        $rose(o_digital_lock_flag) |-> ref_rises >= 8'h04;
    endproperty
    a_lock_needs_edges: assert property (p_lock_needs_edges)
        else $error("lock flag rose with too few reference edges");

    property p_write_answer;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
            o_s_axi_wready |-> ##2 o_s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");

    property p_b_holds;
        o_s_axi_bvalid && !i_s_axi_bready |=>
            o_s_axi_bvalid && $stable(o_s_axi_bresp);
    endproperty
    a_b_holds: assert property (p_b_holds)
        else $error("write response dropped before taken");

    property p_b_release;
        o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid;
    endproperty
    a_b_release: assert property (p_b_release)
        else $error("write response repeated");

    property p_b_blocks;
        o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready;
    endproperty
    a_b_blocks: assert property (p_b_blocks)
        else $error("write accepted while response pending");

    property p_read_answer;
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data late");

    property p_r_holds;
        o_s_axi_rvalid && !i_s_axi_rready |=>
            o_s_axi_rvalid && $stable(o_s_axi_rdata);
    endproperty
    a_r_holds: assert property (p_r_holds)
        else $error("read data changed before taken");

    property p_r_blocks;
        o_s_axi_rvalid |-> !o_s_axi_arready;
    endproperty
    a_r_blocks: assert property (p_r_blocks)
        else $error("read accepted while data pending");

    c_lock: cover property ($rose(o_digital_lock_flag));
    c_loss: cover property ($fell(o_digital_lock_flag));
    c_irq: cover property ($rose(o_irq));
    c_slverr: cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
endmodule

/* File: pfd_edge_model.sv */
// Behavioural source of reference and feedback edges with a set skew
`timescale 1ns/1ns

module pfd_edge_model
(
    input wire logic i_mclk,
    input wire logic i_run,
    input wire logic [4:0] i_skew,
    output logic o_ref,
    output logic o_fb
);
    logic [4:0] phase = 5'h00;
    logic [4:0] skew_hold = 5'h00;
    logic active = 1'b0;

    // Run and skew change only at a period boundary so no edge is orphaned
    always @(posedge i_mclk)
    begin
        phase <= phase + 5'h01;
        if (phase == 5'h1F)
        begin
            active <= i_run;
            skew_hold <= i_skew;
        end
    end

    assign o_ref = active && (phase < 5'h04);
    assign o_fb = active && (phase >= skew_hold) &&
        (phase < skew_hold + 5'h04);
endmodule

/* File: testbench.sv */
// Register and lock behaviour tests for the lock detector
`timescale 1ns/1ns
`include "pll_lock_map.svh"

module testbench;
    localparam logic [7:0] CFG = {`LD_CFG_IDX, 2'b00};
    localparam logic [7:0] STA = {`LD_STATUS_IDX, 2'b00};
    localparam logic [7:0] IST = {`LD_ISTAT_IDX, 2'b00};
    localparam logic [7:0] IMK = {`LD_IMASK_IDX, 2'b00};
    logic mclk, rst, pfd_ref, pfd_fb, run, flag, irq;
    logic [4:0] skew;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] lock_n [4] = '{`LD_CNT_SEL0, `LD_CNT_SEL1, `LD_CNT_SEL2,
        `LD_CNT_SEL3};
    logic [7:0] win_cfg [4] = '{8'h00, 8'h00, 8'h02, 8'h02};
    logic [4:0] win_skew [4] = '{5'h03, 5'h04, 5'h02, 5'h01};
    logic win_lock [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int refs;

    pll_lock_detect pll_lock_detect_inst(.i_mclk(mclk), .i_rst(rst),
        .i_pfd_ref(pfd_ref), .i_pfd_fb(pfd_fb), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_digital_lock_flag(flag), .o_irq(irq));

    pfd_edge_model pfd_edge_model_inst(.i_mclk(mclk), .i_run(run),
        .i_skew(skew), .o_ref(pfd_ref), .o_fb(pfd_fb));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task finish_test;
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            arvalid <= arvalid && !arready;
        end
        while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        axi_read(a, rd, rsp);
        check(n, rd & m, e);
    endtask

    // Stimulus is stopped first so no half pair straddles the enable
    task setup(input logic [7:0] c, input logic [4:0] s);
        run <= 1'b0;
        repeat (72) @(posedge mclk);
        skew <= s;
        axi_write(CFG, {24'h0, c | 8'h01}, rsp);
        repeat (2) @(posedge mclk);
        check("disabled flag", {31'h0, flag}, 32'h0);
        axi_write(CFG, {24'h0, c}, rsp);
    endtask

    task lock_run(input int limit);
        logic prev;
        prev = 1'b0;
        refs = 0;
        run <= 1'b1;
        repeat (limit)
        begin
            @(posedge mclk);
            if (flag === 1'b1)
                break;
            if (pfd_ref && !prev)
                refs++;
            prev = pfd_ref;
        end
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            finish_test;
        end
    end

    initial
    begin
        rst = 1'b1;
        run = 1'b0;
        skew = 5'h01;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd_chk("cfg reset", CFG, 32'hFFFFFFFF, 32'h0);
        rd_chk("mask reset", IMK, 32'hFFFFFFFF, 32'h0);
        axi_read(8'hFC, rd, rsp);
        check("unmapped rresp", {30'h0, rsp}, 32'h2);
        axi_write(8'hFC, 32'h0, rsp);
        check("unmapped bresp", {30'h0, rsp}, 32'h2);
        axi_write(IMK, 32'h3, rsp);
        for (int c = 0; c < 4; c++)
        begin
            setup(8'hF0 | 8'(c << 2), 5'h01);
            lock_run(9000);
            check("lock cycles", refs, {24'h0, lock_n[c]});
            rd_chk("cfg upper", CFG, 32'hFF,
                32'hF0 | 32'(c << 2));
        end
        for (int k = 0; k < 4; k++)
        begin
            setup(win_cfg[k], win_skew[k]);
            lock_run(384);
            check("window", {31'h0, flag},
                {31'h0, win_lock[k]});
        end
        check("irq on lock", {31'h0, irq}, 32'h1);
        rd_chk("status", STA, 32'h0000FF07, 32'h00000105);
        axi_write(IST, 32'h3, rsp);
        rd_chk("irq cleared", IST, 32'hFF, 32'h0);
        check("irq off", {31'h0, irq}, 32'h0);
        skew <= 5'h04;
        repeat (192) @(posedge mclk);
        check("hold at threshold", {31'h0, flag}, 32'h1);
        skew <= 5'h05;
        repeat (96) @(posedge mclk);
        check("loss beyond threshold", {31'h0, flag}, 32'h0);
        rd_chk("lost event", IST, 32'hFF, 32'h2);
        check("irq on loss", {31'h0, irq}, 32'h1);
        axi_write(IMK, 32'h1, rsp);
        repeat (2) @(posedge mclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        skew <= 5'h01;
        axi_write(CFG, 32'h1, rsp);
        repeat (256) @(posedge mclk);
        check("disabled run", {31'h0, flag}, 32'h0);
        rd_chk("state off", STA, 32'h7, 32'h0);
        finish_test;
    end
endmodule

bind pll_lock_detect pll_lock_detect_asserts pll_lock_detect_asserts_inst(
    .i_mclk(i_mclk), .i_rst(i_rst), .i_pfd_ref(i_pfd_ref),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_digital_lock_flag(o_digital_lock_flag), .o_irq(o_irq));
